// *** design/gpd_defs.svh ***
// register offsets, field positions and reset values for the gpio port d block
`ifndef GPD_DEFS_SVH
`define GPD_DEFS_SVH

`define GPD_ADDR_W          4
`define GPD_OFS_PIN_VALUE   4'h0
`define GPD_OFS_LATCH       4'h1
`define GPD_OFS_DIRECTION   4'h2
`define GPD_OFS_PAD_CFG     4'h3
`define GPD_OFS_MEM_CTRL    4'h4
`define GPD_OFS_PSP_CTRL    4'h5
`define GPD_OFS_FUNC_SEL    4'h6
`define GPD_OFS_REMAP_EN    4'h7
`define GPD_OFS_LCD_EN      4'h8

`define GPD_BIT_PULLUP_DIS  7
`define GPD_BIT_BUS_DIS     7
`define GPD_BIT_PSP_MODE    4
`define GPD_BIT_I2C_EN      0
`define GPD_BIT_REFO_EN     1

`define GPD_RST_DIRECTION   8'hFF
`define GPD_RST_LATCH       8'h00
`define GPD_RST_PAD_CFG     8'h80
`define GPD_RST_MEM_CTRL    8'h00
`define GPD_RST_ZERO        8'h00

`define GPD_BIT_DATA        5
`define GPD_BIT_CLOCK       6
`define GPD_BIT_REFO        7

`endif

// *** design/gpd_pkg.sv ***
// types shared by the gpio port d block
`default_nettype none

package gpd_pkg;
  typedef logic [7:0] gpd_byte_t;
  typedef logic [3:0] gpd_addr_t;
  // which function owns the pins as a whole
  typedef enum logic [1:0]
  {
    GPD_OWN_BUS  = 2'b00,
    GPD_OWN_PSP  = 2'b01,
    GPD_OWN_PORT = 2'b10
  } gpd_owner_t;
endpackage : gpd_pkg

`default_nettype wire

// *** design/gpd_port.sv ***
// eight-bit general-purpose port d with its pin function multiplexing
//
// Function
// - The port is eight bits wide with its own direction register and its own output latch.
// - Each pin is made an input or an output by its own direction bit.
// - Every reset leaves all eight pins as digital inputs; here the bus owns them after reset and drives them while MEM_AD_OE is high.
// - Each pin has a weak pull-up and one shared disable bit at pad config bit 7 turns all off.
// - A pin's pull-up is off while its direction bit selects output.
// - Every reset disables all pull-ups.
// - Port and other pin functions, except lcd segments, are usable only once the bus-disable bit is set.
// - With the memory interface on, the pins carry the low address/data byte, overriding direction.
// - The parallel-slave mode bit turns the port into an 8-bit data port with TTL inputs.
// - Bits 5 and 6 also serve as second i2c data and clock, bidirectional whatever direction says.
// - Direction 1 means input and 0 drives the latch, so loading 0xCF makes bits 5:4 outputs.
// - A pin given to an lcd segment loses every other function but the pin value read.
// - Pin 7 may output the second reference clock, only while its direction bit selects output.
// - Memory bus, parallel slave and i2c functions override or ignore the direction bit; remap follows it.
`include "gpd_defs.svh"
`default_nettype none

module gpd_port
  import gpd_pkg::*;
(
  // clock and reset
  input  wire logic           SYS_CLK,
  input  wire logic           RESET_N,
  // register port
  input  wire gpd_pkg::gpd_addr_t ADDR,
  input  wire gpd_pkg::gpd_byte_t WDATA,
  input  wire logic           WR_STB,
  input  wire logic           RD_STB,
  output var  gpd_pkg::gpd_byte_t RDATA,
  // pads
  input  wire gpd_pkg::gpd_byte_t PAD_IN,
  output var  gpd_pkg::gpd_byte_t PAD_OUT,
  output var  gpd_pkg::gpd_byte_t PAD_OE,
  output var  gpd_pkg::gpd_byte_t PAD_PULLUP_EN,
  output var  gpd_pkg::gpd_byte_t PAD_TTL_SEL,
  // external memory bus, low address/data byte
  input  wire gpd_pkg::gpd_byte_t MEM_AD_OUT,
  input  wire logic           MEM_AD_OE,
  output var  gpd_pkg::gpd_byte_t MEM_AD_IN,
  // parallel slave port data
  input  wire gpd_pkg::gpd_byte_t PSP_DATA_OUT,
  input  wire logic           PSP_DATA_OE,
  output var  gpd_pkg::gpd_byte_t PSP_DATA_IN,
  // second i2c channel, open drain
  input  wire logic           I2C_SDA_DRIVE_LOW,
  input  wire logic           I2C_SCL_DRIVE_LOW,
  output var  logic           I2C_SDA_IN,
  output var  logic           I2C_SCL_IN,
  // remappable functions
  input  wire gpd_pkg::gpd_byte_t REMAP_OUT,
  output var  gpd_pkg::gpd_byte_t REMAP_IN,
  // second reference clock
  input  wire logic           REFO_CLK,
  // lcd segments
  input  wire gpd_pkg::gpd_byte_t LCD_SEG_OUT,
  output var  gpd_pkg::gpd_byte_t LCD_SEG_EN
);
  import gpd_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  gpd_byte_t  direction_q;
  gpd_byte_t  latch_q;
  gpd_byte_t  pad_cfg_q;
  gpd_byte_t  mem_ctrl_q;
  gpd_byte_t  psp_ctrl_q;
  gpd_byte_t  func_sel_q;
  gpd_byte_t  remap_en_q;
  gpd_byte_t  lcd_en_q;
  gpd_byte_t  pin_sync_q;
  gpd_byte_t  rdata_q;
  gpd_owner_t owner_d;

  logic wr_dir;
  logic wr_latch;
  assign wr_dir   = WR_STB && (ADDR == `GPD_OFS_DIRECTION);
  assign wr_latch = WR_STB && ((ADDR == `GPD_OFS_LATCH) || (ADDR == `GPD_OFS_PIN_VALUE));

  // direction register, 1 = input
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      direction_q <= `GPD_RST_DIRECTION;
    else if (wr_dir)
      direction_q <= WDATA;
  end

  // output latch, reachable through either address
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      latch_q <= `GPD_RST_LATCH;
    else if (wr_latch)
      latch_q <= WDATA;
  end

  // control registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      pad_cfg_q  <= `GPD_RST_PAD_CFG;
      mem_ctrl_q <= `GPD_RST_MEM_CTRL;
      psp_ctrl_q <= `GPD_RST_ZERO;
      func_sel_q <= `GPD_RST_ZERO;
      remap_en_q <= `GPD_RST_ZERO;
      lcd_en_q   <= `GPD_RST_ZERO;
    end
    else if (WR_STB)
    begin
      case (ADDR)
        `GPD_OFS_PAD_CFG:  pad_cfg_q  <= WDATA;
        `GPD_OFS_MEM_CTRL: mem_ctrl_q <= WDATA;
        `GPD_OFS_PSP_CTRL: psp_ctrl_q <= WDATA;
        `GPD_OFS_FUNC_SEL: func_sel_q <= WDATA;
        `GPD_OFS_REMAP_EN: remap_en_q <= WDATA;
        `GPD_OFS_LCD_EN:   lcd_en_q   <= WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and read port
  // ----------------------------------------------------------------
  // pads are taken as synchronous; one stage gives a clean register view
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      pin_sync_q <= `GPD_RST_ZERO;
    else
      pin_sync_q <= PAD_IN;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      rdata_q <= `GPD_RST_ZERO;
    else if (RD_STB)
    begin
      case (ADDR)
        `GPD_OFS_PIN_VALUE: rdata_q <= pin_sync_q;
        `GPD_OFS_LATCH:     rdata_q <= latch_q;
        `GPD_OFS_DIRECTION: rdata_q <= direction_q;
        `GPD_OFS_PAD_CFG:   rdata_q <= pad_cfg_q;
        `GPD_OFS_MEM_CTRL:  rdata_q <= mem_ctrl_q;
        `GPD_OFS_PSP_CTRL:  rdata_q <= psp_ctrl_q;
        `GPD_OFS_FUNC_SEL:  rdata_q <= func_sel_q;
        `GPD_OFS_REMAP_EN:  rdata_q <= remap_en_q;
        `GPD_OFS_LCD_EN:    rdata_q <= lcd_en_q;
        default:            rdata_q <= `GPD_RST_ZERO;
      endcase
    end
    else
      rdata_q <= `GPD_RST_ZERO;
  end
  assign RDATA = rdata_q;

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  // bus holds the pins until software sets the bus-disable bit
  always_comb
  begin
    if (!mem_ctrl_q[`GPD_BIT_BUS_DIS])
      owner_d = GPD_OWN_BUS;
    else if (psp_ctrl_q[`GPD_BIT_PSP_MODE])
      owner_d = GPD_OWN_PSP;
    else
      owner_d = GPD_OWN_PORT;
  end

  // ----------------------------------------------------------------
  // per-pin output mux, registered so pad drives come from flops
  // ----------------------------------------------------------------
  gpd_byte_t out_d;
  gpd_byte_t oe_d;
  gpd_byte_t pu_d;
  gpd_byte_t out_q;
  gpd_byte_t oe_q;
  gpd_byte_t pu_q;
  gpd_byte_t ttl_q;
  gpd_byte_t seg_q;
  logic      i2c_on;
  logic      refo_on;

  assign i2c_on  = func_sel_q[`GPD_BIT_I2C_EN];
  assign refo_on = func_sel_q[`GPD_BIT_REFO_EN];

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      out_d[i] = latch_q[i];
      oe_d[i]  = !direction_q[i];
      case (owner_d)
        GPD_OWN_BUS:
        begin
          out_d[i] = MEM_AD_OUT[i];
          oe_d[i]  = MEM_AD_OE;
        end
        GPD_OWN_PSP:
        begin
          out_d[i] = PSP_DATA_OUT[i];
          oe_d[i]  = PSP_DATA_OE;
        end
        GPD_OWN_PORT:
        begin
          if (remap_en_q[i])
          begin
            // remap follows the direction bit software set to match
            out_d[i] = REMAP_OUT[i];
            oe_d[i]  = !direction_q[i];
          end
        end
        default:
        begin
          out_d[i] = latch_q[i];
          oe_d[i]  = 1'b0;
        end
      endcase
      // lcd segment takes the pin from every other function
      if (lcd_en_q[i])
      begin
        out_d[i] = LCD_SEG_OUT[i];
        oe_d[i]  = 1'b1;
      end
    end
    // i2c pins drive low only, whatever direction says
    if (owner_d == GPD_OWN_PORT && i2c_on)
    begin
      if (!lcd_en_q[`GPD_BIT_DATA])
      begin
        out_d[`GPD_BIT_DATA] = 1'b0;
        oe_d[`GPD_BIT_DATA]  = I2C_SDA_DRIVE_LOW;
      end
      if (!lcd_en_q[`GPD_BIT_CLOCK])
      begin
        out_d[`GPD_BIT_CLOCK] = 1'b0;
        oe_d[`GPD_BIT_CLOCK]  = I2C_SCL_DRIVE_LOW;
      end
    end
    // reference clock needs the pin set as output
    if (owner_d == GPD_OWN_PORT && refo_on && !direction_q[`GPD_BIT_REFO]
        && !lcd_en_q[`GPD_BIT_REFO])
      out_d[`GPD_BIT_REFO] = REFO_CLK;
  end

  // ----------------------------------------------------------------
  // weak pull-ups
  // ----------------------------------------------------------------
  // decided after every override, so a driven pad never keeps its pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pu_d[i] = !pad_cfg_q[`GPD_BIT_PULLUP_DIS] && direction_q[i] && !oe_d[i]
                && !lcd_en_q[i] && (owner_d == GPD_OWN_PORT);
    end
  end

  // pad drive
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      out_q <= `GPD_RST_ZERO;
      oe_q  <= `GPD_RST_ZERO;
    end
    else
    begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  // pull-up enables
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      pu_q <= `GPD_RST_ZERO;
    else
      pu_q <= pu_d;
  end

  // input buffer type follows parallel-slave ownership
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      ttl_q <= `GPD_RST_ZERO;
    else
      ttl_q <= (owner_d == GPD_OWN_PSP) ? 8'hFF : 8'h00;
  end

  // segment enables shown to the lcd side
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      seg_q <= `GPD_RST_ZERO;
    else
      seg_q <= lcd_en_q;
  end

  assign PAD_OUT       = out_q;
  assign PAD_OE        = oe_q;
  assign PAD_PULLUP_EN = pu_q;
  assign PAD_TTL_SEL   = ttl_q;
  assign LCD_SEG_EN    = seg_q;

  // ----------------------------------------------------------------
  // inputs returned to the functions
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      MEM_AD_IN   <= `GPD_RST_ZERO;
      PSP_DATA_IN <= `GPD_RST_ZERO;
      REMAP_IN    <= `GPD_RST_ZERO;
    end
    else
    begin
      MEM_AD_IN   <= PAD_IN & ~lcd_en_q;
      PSP_DATA_IN <= PAD_IN & ~lcd_en_q;
      REMAP_IN    <= PAD_IN & remap_en_q & ~lcd_en_q;
    end
  end

  // i2c lines idle high, also while a segment owns the pin
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      I2C_SDA_IN <= 1'b1;
      I2C_SCL_IN <= 1'b1;
    end
    else
    begin
      I2C_SDA_IN <= PAD_IN[`GPD_BIT_DATA] | lcd_en_q[`GPD_BIT_DATA];
      I2C_SCL_IN <= PAD_IN[`GPD_BIT_CLOCK] | lcd_en_q[`GPD_BIT_CLOCK];
    end
  end
endmodule : gpd_port

`default_nettype wire

// *** verif/gpd_pad_model.sv ***
// pad model: resolves each pad from drives, pull-ups and outside sources
`default_nettype none
module gpd_pad_model
  import gpd_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire gpd_pkg::gpd_byte_t pad_out,
  input  wire gpd_pkg::gpd_byte_t pad_oe,
  input  wire gpd_pkg::gpd_byte_t pull_en,
  input  wire gpd_pkg::gpd_byte_t ext_lvl,
  input  wire gpd_pkg::gpd_byte_t ext_en,
  output var  gpd_pkg::gpd_byte_t pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  gpd_byte_t flt_q = 8'h55;
  // undriven pads wander so a stale value cannot pass
  always @(posedge sys_clk)
    flt_q <= ~flt_q;
  always_comb
    for (int i = 0; i < 8; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_lvl[i] :
                  pull_en[i] ? 1'b1 : flt_q[i];
endmodule : gpd_pad_model
`default_nettype wire

// *** verif/gpd_port_checker.sv ***
// assertion checker for the gpio port d block
`default_nettype none
module gpd_port_checker
  import gpd_pkg::*;
(
  input wire logic               SYS_CLK,
  input wire logic               RESET_N,
  input wire gpd_pkg::gpd_addr_t ADDR,
  input wire gpd_pkg::gpd_byte_t WDATA,
  input wire logic               WR_STB,
  input wire logic               RD_STB,
  input wire gpd_pkg::gpd_byte_t RDATA,
  input wire gpd_pkg::gpd_byte_t PAD_IN,
  input wire gpd_pkg::gpd_byte_t PAD_OE,
  input wire gpd_pkg::gpd_byte_t PAD_PULLUP_EN,
  input wire gpd_pkg::gpd_byte_t PAD_TTL_SEL,
  input wire gpd_pkg::gpd_byte_t LCD_SEG_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  chk_reset_inputs: assert property ($rose(RESET_N) |-> PAD_OE == 8'h00)
    else $error("pins driven after reset");
  chk_reset_pullups: assert property ($rose(RESET_N) |-> PAD_PULLUP_EN == 8'h00)
    else $error("pull-ups on after reset");
  chk_pullup_output: assert property ((PAD_PULLUP_EN & PAD_OE) == 8'h00)
    else $error("pull-up on a driven pin");
  chk_pullup_disable: assert property (WR_STB && ADDR == 4'h3 && WDATA[7]
    |-> ##2 PAD_PULLUP_EN == 8'h00)
    else $error("pull-ups not off after disable");
  chk_lcd_pullup: assert property ((LCD_SEG_EN & PAD_PULLUP_EN) == 8'h00)
    else $error("pull-up on a segment pin");
  chk_pin_read: assert property (RD_STB && ADDR == 4'h0 |=> RDATA == $past(PAD_IN, 2))
    else $error("pin read wrong");
  chk_read_idle: assert property (!RD_STB |=> RDATA == 8'h00)
    else $error("read data outside read");
  chk_unmapped_read: assert property (RD_STB && ADDR > 4'h8 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  cover property (RD_STB && ADDR == 4'h0);
  cover property (PAD_TTL_SEL == 8'hFF);
  cover property (LCD_SEG_EN != 8'h00);
endmodule : gpd_port_checker

bind gpd_port gpd_port_checker gpd_port_checker_inst (.SYS_CLK, .RESET_N, .ADDR, .WDATA,
  .WR_STB, .RD_STB, .RDATA, .PAD_IN, .PAD_OE, .PAD_PULLUP_EN, .PAD_TTL_SEL, .LCD_SEG_EN);
`default_nettype wire

// *** verif/gpd_port_tb.sv ***
// self-checking bench for the gpio port d block
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module gpd_port_tb
  import gpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // ports share the design's names so the instance binds by name
  // ------------------------------------------------------------
  logic SYS_CLK = 1'b0, RESET_N = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0, MEM_AD_OE = 1'b0;
  logic PSP_DATA_OE = 1'b0, I2C_SDA_DRIVE_LOW = 1'b0, I2C_SCL_DRIVE_LOW = 1'b0;
  logic REFO_CLK = 1'b0, rp = 1'b0, I2C_SDA_IN, I2C_SCL_IN;
  gpd_addr_t ADDR = 4'h0;
  gpd_byte_t WDATA = 8'h00, MEM_AD_OUT = 8'h00, PSP_DATA_OUT = 8'h00, REMAP_OUT = 8'h00;
  gpd_byte_t LCD_SEG_OUT = 8'h00, EXT_LVL = 8'h00, RDATA, PAD_IN, PAD_OUT, PAD_OE;
  gpd_byte_t PAD_PULLUP_EN, PAD_TTL_SEL, MEM_AD_IN, PSP_DATA_IN, REMAP_IN, LCD_SEG_EN;
  gpd_byte_t EXT_EN = 8'hFF, rd_exp;
  gpd_byte_t q[$];
  int fail_count = 0, n_checks = 0;
  logic [15:0] lfsr = 16'hA337;
  gpd_port gpd_port_inst (.SYS_CLK, .RESET_N, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
    .PAD_IN, .PAD_OUT, .PAD_OE, .PAD_PULLUP_EN, .PAD_TTL_SEL, .MEM_AD_OUT, .MEM_AD_OE,
    .MEM_AD_IN, .PSP_DATA_OUT, .PSP_DATA_OE, .PSP_DATA_IN, .I2C_SDA_DRIVE_LOW,
    .I2C_SCL_DRIVE_LOW, .I2C_SDA_IN, .I2C_SCL_IN, .REMAP_OUT, .REMAP_IN, .REFO_CLK,
    .LCD_SEG_OUT, .LCD_SEG_EN);
  gpd_pad_model gpd_pad_model_inst (.sys_clk(SYS_CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
    .pull_en(PAD_PULLUP_EN), .ext_lvl(EXT_LVL), .ext_en(EXT_EN), .pad_in(PAD_IN));
  always #5 SYS_CLK = ~SYS_CLK;
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic wr(gpd_addr_t a, gpd_byte_t d);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    RD_STB <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wr
  task automatic rd(gpd_addr_t a, gpd_byte_t e);
    ADDR <= a;
    RD_STB <= 1'b1;
    WR_STB <= 1'b0;
    q.push_back(e);
    @(posedge SYS_CLK);
  endtask : rd
  // strobes drop, then outputs get three edges plus margin to settle
  task automatic st();
    WR_STB <= 1'b0;
    RD_STB <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask : st
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge SYS_CLK)
  begin
    if (rp)
    begin
      rd_exp = q.pop_front();
      `CHK(RDATA, rd_exp)
    end
    rp <= RD_STB;
  end
  initial
  begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    st();
    `CHK(PAD_OE, 8'h00)
    `CHK(PAD_PULLUP_EN, 8'h00)
    rd(4'h2, 8'hFF);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h80);
    rd(4'hF, 8'h00);
    wr(4'h2, 8'h00);
    MEM_AD_OE <= 1'b1;
    MEM_AD_OUT <= 8'hA5;
    st();
    `CHK(PAD_OE, 8'hFF)
    `CHK(PAD_OUT, 8'hA5)
    `CHK(MEM_AD_IN, 8'hA5)
    MEM_AD_OE <= 1'b0;
    wr(4'h4, 8'h80);
    wr(4'h0, 8'h5A);
    wr(4'h2, 8'hCF);
    wr(4'h3, 8'h00);
    st();
    `CHK(PAD_OE, 8'h30)
    `CHK(PAD_OUT & 8'h30, 8'h10)
    `CHK(PAD_PULLUP_EN, 8'hCF)
    rd(4'h1, 8'h5A);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      EXT_LVL <= lfsr[7:0];
      REMAP_OUT <= lfsr[15:8];
      st();
      rd(4'h0, 8'h10 | (lfsr[7:0] & 8'hCF));
    end
    EXT_EN <= 8'h00;
    st();
    rd(4'h0, 8'hDF);
    EXT_EN <= 8'hFF;
    wr(4'h3, 8'h80);
    wr(4'h7, 8'h01);
    wr(4'h2, 8'hCE);
    st();
    `CHK(PAD_PULLUP_EN, 8'h00)
    `CHK({PAD_OE[0], PAD_OUT[0]}, {1'b1, lfsr[8]})
    `CHK(REMAP_IN, {7'h00, lfsr[8]})
    wr(4'h7, 8'h00);
    wr(4'h6, 8'h01);
    I2C_SCL_DRIVE_LOW <= 1'b1;
    st();
    `CHK(PAD_OE[6:5], 2'b10)
    `CHK(I2C_SCL_IN, 1'b0)
    `CHK(I2C_SDA_IN, lfsr[5])
    I2C_SCL_DRIVE_LOW <= 1'b0;
    wr(4'h6, 8'h02);
    wr(4'h2, 8'h4E);
    REFO_CLK <= 1'b1;
    st();
    `CHK(PAD_OUT[7], 1'b1)
    wr(4'h2, 8'hCE);
    st();
    `CHK({PAD_OE[7], PAD_OUT[7]}, 2'b00)
    REFO_CLK <= 1'b0;
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h10);
    PSP_DATA_OE <= 1'b1;
    PSP_DATA_OUT <= 8'h3C;
    st();
    `CHK(PAD_TTL_SEL, 8'hFF)
    `CHK({PAD_OE, PAD_OUT}, 16'hFF3C)
    `CHK(PSP_DATA_IN, 8'h3C)
    wr(4'h8, 8'h01);
    LCD_SEG_OUT <= 8'hFF;
    st();
    `CHK(LCD_SEG_EN, 8'h01)
    `CHK(PAD_OE[7:1], 7'h7F)
    `CHK({PAD_OE[0], PAD_OUT[0]}, 2'b11)
    `CHK(PSP_DATA_IN, 8'h3C)
    RESET_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    st();
    `CHK({PAD_OE, LCD_SEG_EN}, 16'h0000)
    `CHK(PAD_PULLUP_EN, 8'h00)
    rd(4'h2, 8'hFF);
    st();
    complete_run();
  end
endmodule : gpd_port_tb
`default_nettype wire
